// ===== logic/gexp_pkg.sv
// Overview of operation
// - After the address byte, the master's command byte is stored as the register pointer.
// - All eight pointer bits are decoded; any other code reads 00h and ignores writes.
// - The pointer is written only by the command byte and is never read back.
// - Codes 00h to 03h select pin level, drive level, invert mask and direction.
// - Codes 40h to 46h and 4Fh select the extended registers in table order.
// - Pin level bits return each pin's current level, input or output.
// - Writes to the pin level register are ignored and change nothing.
// - Pin level has no reset value; it follows the external pin levels.
// - Drive level bits reach a pin only while that pin is an output.
// - Reading drive level returns the last written value, not the pins.
// - An invert bit of 1 inverts the reported pin level; 0 leaves it unchanged.
// - Inversion applies only to pins configured as inputs.
// - Direction 1 makes a high-impedance input; 0 enables the output driver.
// - Each pin has a two-bit drive strength: quarter, half, three-quarter, full.
// - Pins 0 to 3 sit in the low strength register, 4 to 7 in the high one.
// - Slave address is 010000 then the select pin; last bit 1 reads, 0 writes.
// - The address select pin chooses one of two slave addresses.
package gexp_pkg;

  localparam logic [5:0] GEXP_ADDR_BASE = 6'h10;

  localparam logic [7:0] GEXP_PTR_PIN_LEVEL = 8'h00;
  localparam logic [7:0] GEXP_PTR_DRIVE_LEVEL = 8'h01;
  localparam logic [7:0] GEXP_PTR_INVERT = 8'h02;
  localparam logic [7:0] GEXP_PTR_DIRECTION = 8'h03;
  localparam logic [7:0] GEXP_PTR_STRENGTH_LOW = 8'h40;
  localparam logic [7:0] GEXP_PTR_STRENGTH_HIGH = 8'h41;
  localparam logic [7:0] GEXP_PTR_LATCH = 8'h42;
  localparam logic [7:0] GEXP_PTR_PULL_EN = 8'h43;
  localparam logic [7:0] GEXP_PTR_PULL_SEL = 8'h44;
  localparam logic [7:0] GEXP_PTR_IRQ_MASK = 8'h45;
  localparam logic [7:0] GEXP_PTR_IRQ_SOURCE = 8'h46;
  localparam logic [7:0] GEXP_PTR_OUT_STAGE = 8'h4f;

  localparam int GEXP_EXT_BIT = 6;

  localparam logic [7:0] GEXP_RST_DRIVE_LEVEL = 8'hff;
  localparam logic [7:0] GEXP_RST_INVERT = 8'h00;
  localparam logic [7:0] GEXP_RST_DIRECTION = 8'hff;
  localparam logic [7:0] GEXP_RST_STRENGTH = 8'hff;
  localparam logic [7:0] GEXP_RST_LATCH = 8'h00;
  localparam logic [7:0] GEXP_RST_PULL_EN = 8'h00;
  localparam logic [7:0] GEXP_RST_PULL_SEL = 8'hff;
  localparam logic [7:0] GEXP_RST_IRQ_MASK = 8'hff;
  localparam logic [7:0] GEXP_RST_OUT_STAGE = 8'h00;

  typedef enum logic [2:0] {
    GEXP_IDLE = 3'b000,
    GEXP_ADDR = 3'b001,
    GEXP_ADDR_ACK = 3'b011,
    GEXP_WR_BYTE = 3'b010,
    GEXP_WR_ACK = 3'b110,
    GEXP_RD_BYTE = 3'b111,
    GEXP_RD_ACK = 3'b101,
    GEXP_SKIP = 3'b100
  } gexp_state_t;

  typedef struct packed {
    logic [7:0] drive_level;
    logic [7:0] invert_mask;
    logic [7:0] direction;
    logic [7:0] strength_low;
    logic [7:0] strength_high;
    logic [7:0] latch_enable;
    logic [7:0] pull_enable;
    logic [7:0] pull_select;
    logic [7:0] irq_mask;
    logic [7:0] out_stage;
  } gexp_regs_t;

  typedef struct packed {
    logic [7:0] pin_drive;
    logic [7:0] pin_oe;
    logic [15:0] drive_strength_fields;
    logic [7:0] pull_enable;
    logic [7:0] pull_select;
    logic open_drain;
  } gexp_port_ctl_t;

endpackage

// ===== logic/gexp_regs.sv
`timescale 1ns/10ps
module gexp_regs
  import gexp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_scl_clock,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_addr_sel,
  input wire logic [7:0] i_pin_level_bits,
  output gexp_port_ctl_t o_port_ctl
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic ptr_known(input logic [7:0] p);
    case (p)
      GEXP_PTR_PIN_LEVEL, GEXP_PTR_DRIVE_LEVEL, GEXP_PTR_INVERT, GEXP_PTR_DIRECTION,
      GEXP_PTR_STRENGTH_LOW, GEXP_PTR_STRENGTH_HIGH, GEXP_PTR_LATCH, GEXP_PTR_PULL_EN,
      GEXP_PTR_PULL_SEL, GEXP_PTR_IRQ_MASK, GEXP_PTR_IRQ_SOURCE,
      GEXP_PTR_OUT_STAGE: ptr_known = 1'b1;
      default: ptr_known = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] gray_inc(input logic [7:0] g);
    logic [7:0] b;
    b = g;
    for (int i = 6; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    b = b + 8'h01;
    gray_inc = b ^ (b >> 1);
  endfunction

  // ****************************************************************
  // Start and stop detection, system clock domain
  // ****************************************************************
  // Start/stop are seen as SDA edges while SCL is high; sampled on the
  // system clock through two-flop synchronisers.
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic start_tog_reg;
  logic stop_tog_reg;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      start_tog_reg <= 1'b0;
      stop_tog_reg <= 1'b0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], i_scl_clock};
      sda_sync_reg <= {sda_sync_reg[0], i_sda_in};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
      if (scl_sync_reg[1] && scl_d_reg && sda_d_reg && !sda_sync_reg[1]) begin
        start_tog_reg <= ~start_tog_reg;
      end
      if (scl_sync_reg[1] && scl_d_reg && !sda_d_reg && sda_sync_reg[1]) begin
        stop_tog_reg <= ~stop_tog_reg;
      end
    end
  end

  // Events crossing into the link domain as toggles
  logic [2:0] start_ls_reg;
  always_ff @(posedge i_scl_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      start_ls_reg <= 3'h0;
    end else begin
      start_ls_reg <= {start_ls_reg[1:0], start_tog_reg};
    end
  end

  // ****************************************************************
  // Link logic on the bus clock
  // ****************************************************************
  typedef struct packed {
    gexp_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic first_wr;
    logic [7:0] pointer;
    logic wr_valid;
    logic [7:0] wr_ptr;
    logic [7:0] wr_data;
    logic wr_tog;
    logic [7:0] rd_req;
    logic rd_tog;
    logic start_seen;
    logic stop_seen;
    logic [2:0] hist;
  } gexp_link_t;

  gexp_link_t link_reg;
  gexp_link_t link_next;
  logic [1:0] stop_ls_reg;
  logic [7:0] rd_data_reg;
  logic sda_low_reg;

  // Address select strap, brought into the link domain
  logic [1:0] sel_sync_reg;

  always_ff @(posedge i_scl_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      stop_ls_reg <= 2'h0;
      sel_sync_reg <= 2'h0;
    end else begin
      stop_ls_reg <= {stop_ls_reg[0], stop_tog_reg};
      sel_sync_reg <= {sel_sync_reg[0], i_addr_sel};
    end
  end

  wire logic start_ev = start_ls_reg[2] ^ link_reg.start_seen;
  wire logic stop_ev = stop_ls_reg[1] ^ link_reg.stop_seen;
  wire logic [7:0] shifted = {link_reg.shift[6:0], i_sda_in};

  always_comb begin
    link_next = link_reg;
    link_next.start_seen = start_ls_reg[2];
    link_next.stop_seen = stop_ls_reg[1];
    link_next.bit_cnt = link_reg.bit_cnt + 4'h1;
    link_next.hist = {link_reg.hist[1:0], i_sda_in};
    if (start_ev) begin
      // The start toggle crosses on bus clock rises only, so it is seen at
      // the fourth address bit; the first three come from the bit history
      link_next.state = GEXP_ADDR;
      link_next.shift = {4'h0, link_reg.hist, i_sda_in};
      link_next.bit_cnt = 4'h4;
    end else if (stop_ev) begin
      link_next.state = GEXP_IDLE;
    end else begin
      case (link_reg.state)
        GEXP_IDLE: begin
          link_next.bit_cnt = 4'h0;
        end
        GEXP_ADDR: begin
          link_next.shift = shifted;
          if (link_reg.bit_cnt == 4'h7) begin
            link_next.rw = i_sda_in;
            if (shifted[7:1] == {GEXP_ADDR_BASE, sel_sync_reg[1]}) begin
              link_next.state = GEXP_ADDR_ACK;
            end else begin
              link_next.state = GEXP_SKIP;
            end
          end
        end
        GEXP_ADDR_ACK: begin
          link_next.bit_cnt = 4'h0;
          link_next.first_wr = 1'b1;
          if (link_reg.rw) begin
            link_next.state = GEXP_RD_BYTE;
            link_next.shift = rd_data_reg;
          end else begin
            link_next.state = GEXP_WR_BYTE;
          end
        end
        GEXP_WR_BYTE: begin
          link_next.shift = shifted;
          if (link_reg.bit_cnt == 4'h7) begin
            link_next.state = GEXP_WR_ACK;
            if (link_reg.first_wr) begin
              link_next.pointer = shifted;
            end else begin
              link_next.wr_ptr = link_reg.pointer;
              link_next.wr_data = shifted;
              link_next.wr_tog = ~link_reg.wr_tog;
            end
          end
        end
        GEXP_WR_ACK: begin
          link_next.bit_cnt = 4'h0;
          link_next.first_wr = 1'b0;
          link_next.state = GEXP_WR_BYTE;
          if (link_reg.first_wr) begin
            link_next.rd_req = link_reg.pointer;
            link_next.rd_tog = ~link_reg.rd_tog;
          end
        end
        GEXP_RD_BYTE: begin
          link_next.shift = {link_reg.shift[6:0], 1'b0};
          if (link_reg.bit_cnt == 4'h7) begin
            link_next.state = GEXP_RD_ACK;
          end
        end
        GEXP_RD_ACK: begin
          link_next.bit_cnt = 4'h0;
          link_next.state = i_sda_in ? GEXP_SKIP : GEXP_RD_BYTE;
          link_next.shift = rd_data_reg;
          link_next.rd_req = link_reg.pointer;
          link_next.rd_tog = ~link_reg.rd_tog;
        end
        default: begin
          link_next.bit_cnt = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge i_scl_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // SDA changes while SCL is low
  always_ff @(negedge i_scl_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sda_low_reg <= 1'b0;
    end else begin
      sda_low_reg <= (link_reg.state == GEXP_ADDR_ACK) || (link_reg.state == GEXP_WR_ACK) ||
                     ((link_reg.state == GEXP_RD_BYTE) && !link_reg.shift[7]);
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe = sda_low_reg;

  // ****************************************************************
  // Register file, system clock domain
  // ****************************************************************
  typedef struct packed {
    gexp_regs_t regs;
    logic [2:0] wr_sync;
    logic [2:0] rd_sync;
    logic [7:0] rd_data;
    logic [15:0] pin_sync;
  } gexp_core_t;

  gexp_core_t core_reg;
  gexp_core_t core_next;
  logic [7:0] pins_now;
  logic [7:0] reported;
  logic [7:0] rd_value;

  assign pins_now = core_reg.pin_sync[15:8];
  // Inversion only on input pins
  assign reported = pins_now ^ (core_reg.regs.invert_mask & core_reg.regs.direction);

  always_comb begin
    rd_value = 8'h00;
    case (link_reg.rd_req)
      GEXP_PTR_PIN_LEVEL: rd_value = reported;
      GEXP_PTR_DRIVE_LEVEL: rd_value = core_reg.regs.drive_level;
      GEXP_PTR_INVERT: rd_value = core_reg.regs.invert_mask;
      GEXP_PTR_DIRECTION: rd_value = core_reg.regs.direction;
      GEXP_PTR_STRENGTH_LOW: rd_value = core_reg.regs.strength_low;
      GEXP_PTR_STRENGTH_HIGH: rd_value = core_reg.regs.strength_high;
      GEXP_PTR_LATCH: rd_value = core_reg.regs.latch_enable;
      GEXP_PTR_PULL_EN: rd_value = core_reg.regs.pull_enable;
      GEXP_PTR_PULL_SEL: rd_value = core_reg.regs.pull_select;
      GEXP_PTR_IRQ_MASK: rd_value = core_reg.regs.irq_mask;
      GEXP_PTR_IRQ_SOURCE: rd_value = 8'h00;
      GEXP_PTR_OUT_STAGE: rd_value = core_reg.regs.out_stage;
      default: rd_value = 8'h00;
    endcase
  end

  always_comb begin
    core_next = core_reg;
    core_next.pin_sync = {core_reg.pin_sync[7:0], i_pin_level_bits};
    core_next.wr_sync = {core_reg.wr_sync[1:0], link_reg.wr_tog};
    core_next.rd_sync = {core_reg.rd_sync[1:0], link_reg.rd_tog};
    if (core_reg.rd_sync[2] != core_reg.rd_sync[1]) begin
      core_next.rd_data = rd_value;
    end
    if ((core_reg.wr_sync[2] != core_reg.wr_sync[1]) && ptr_known(link_reg.wr_ptr)) begin
      case (link_reg.wr_ptr)
        GEXP_PTR_PIN_LEVEL: core_next.regs = core_reg.regs;
        GEXP_PTR_DRIVE_LEVEL: core_next.regs.drive_level = link_reg.wr_data;
        GEXP_PTR_INVERT: core_next.regs.invert_mask = link_reg.wr_data;
        GEXP_PTR_DIRECTION: core_next.regs.direction = link_reg.wr_data;
        GEXP_PTR_STRENGTH_LOW: core_next.regs.strength_low = link_reg.wr_data;
        GEXP_PTR_STRENGTH_HIGH: core_next.regs.strength_high = link_reg.wr_data;
        GEXP_PTR_LATCH: core_next.regs.latch_enable = link_reg.wr_data;
        GEXP_PTR_PULL_EN: core_next.regs.pull_enable = link_reg.wr_data;
        GEXP_PTR_PULL_SEL: core_next.regs.pull_select = link_reg.wr_data;
        GEXP_PTR_IRQ_MASK: core_next.regs.irq_mask = link_reg.wr_data;
        GEXP_PTR_OUT_STAGE: core_next.regs.out_stage = {7'h00, link_reg.wr_data[0]};
        default: core_next.regs = core_reg.regs;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      core_reg.regs <= '{
        drive_level: GEXP_RST_DRIVE_LEVEL,
        invert_mask: GEXP_RST_INVERT,
        direction: GEXP_RST_DIRECTION,
        strength_low: GEXP_RST_STRENGTH,
        strength_high: GEXP_RST_STRENGTH,
        latch_enable: GEXP_RST_LATCH,
        pull_enable: GEXP_RST_PULL_EN,
        pull_select: GEXP_RST_PULL_SEL,
        irq_mask: GEXP_RST_IRQ_MASK,
        out_stage: GEXP_RST_OUT_STAGE
      };
      core_reg.wr_sync <= 3'h0;
      core_reg.rd_sync <= 3'h0;
      core_reg.rd_data <= 8'h00;
      core_reg.pin_sync <= 16'h0000;
    end else begin
      core_reg <= core_next;
    end
  end

  // Read data settles long before the link loads it one bus bit later
  always_ff @(posedge i_scl_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= core_reg.rd_data;
    end
  end

  // ****************************************************************
  // Port control
  // ****************************************************************
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_port_ctl <= '{8'hff, 8'h00, 16'hffff, 8'h00, 8'hff, 1'b0};
    end else begin
      o_port_ctl.pin_drive <= core_reg.regs.drive_level;
      o_port_ctl.pin_oe <= ~core_reg.regs.direction;
      o_port_ctl.drive_strength_fields <= {core_reg.regs.strength_high,
                                           core_reg.regs.strength_low};
      o_port_ctl.pull_enable <= core_reg.regs.pull_enable;
      o_port_ctl.pull_select <= core_reg.regs.pull_select;
      o_port_ctl.open_drain <= core_reg.regs.out_stage[0];
    end
  end

endmodule

// ===== verif/gexp_master.sv
`timescale 1ns/10ps
// ****************
// Bus master model
// ****************
module gexp_master (
  input wire logic i_sda_oe,
  output logic o_scl,
  output logic o_sda
);
  logic sda_drive = 1'b1;
  initial begin
    o_scl = 1'b1;
  end
  // Open-drain wire with pull-up
  assign o_sda = sda_drive & ~i_sda_oe;
  task automatic bit_io(input logic b, output logic r);
    o_scl = 1'b0;
    #20 sda_drive = b;
    #60 o_scl = 1'b1;
    r = o_sda;
    #80;
  endtask
  task automatic start(input logic rep);
    if (rep) begin
      o_scl = 1'b0;
      #20 sda_drive = 1'b1;
      #60 o_scl = 1'b1;
    end
    #53 sda_drive = 1'b0;
    #40;
  endtask
  task automatic stop();
    o_scl = 1'b0;
    #20 sda_drive = 1'b0;
    #60 o_scl = 1'b1;
    #40 sda_drive = 1'b1;
    #80;
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
      output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      q = {q[6:0], b};
    end
    bit_io(mack, ack);
  endtask
endmodule

// ===== verif/gexp_regs_props.sv
`timescale 1ns/10ps
// ****************
// Bus and port checks
// ****************
module gexp_regs_props
  import gexp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_scl_clock,
  input wire logic i_sda_in,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic i_addr_sel,
  input wire logic [7:0] i_pin_level_bits,
  input wire gexp_port_ctl_t o_port_ctl
);
  sequence s_start;
    i_scl_clock && $fell(i_sda_in);
  endsequence
  sequence s_stop;
    i_scl_clock && $rose(i_sda_in);
  endsequence
  property p_reset_values;
    @(posedge i_clock) disable iff (!i_resetn)
    $rose(i_resetn) |-> !o_sda_oe && o_port_ctl.pin_oe == 8'h00 && o_port_ctl.pin_drive == 8'hff
      && o_port_ctl.drive_strength_fields == 16'hffff && o_port_ctl.pull_enable == 8'h00
      && o_port_ctl.pull_select == 8'hff && !o_port_ctl.open_drain;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad state after reset");
  property p_sda_low;
    @(posedge i_clock) disable iff (!i_resetn) o_sda_out == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("data line driven high");
  property p_oe_scl_low;
    @(posedge i_clock) disable iff (!i_resetn) $changed(o_sda_oe) |-> !i_scl_clock;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved with clock high");
  property p_oe_stands;
    @(posedge i_clock) disable iff (!i_resetn) $rose(o_sda_oe) |-> o_sda_oe [*6];
  endproperty
  a_oe_stands: assert property (p_oe_stands) else $error("bit shorter than a period");
  property p_start_quiet;
    @(posedge i_clock) disable iff (!i_resetn) s_start |-> !o_sda_oe [*8];
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("drive during address");
  property p_stop_quiet;
    @(posedge i_clock) disable iff (!i_resetn) s_stop |-> !o_sda_oe [*4];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("drive after stop");
  property p_ctl_after_ack;
    // A register update lands while the device still acknowledges the data byte
    @(posedge i_clock) disable iff (!i_resetn) $changed(o_port_ctl) |-> o_sda_oe;
  endproperty
  a_ctl_after_ack: assert property (p_ctl_after_ack) else $error("port moved off a write");
  property p_one_reg;
    @(posedge i_clock) disable iff (!i_resetn) $changed(o_port_ctl.pin_drive)
      |-> $stable(o_port_ctl.pin_oe) && $stable(o_port_ctl.drive_strength_fields);
  endproperty
  a_one_reg: assert property (p_one_reg) else $error("one write moved two registers");
endmodule
bind gexp_regs gexp_regs_props u_props (.i_clock(i_clock), .i_resetn(i_resetn),
  .i_scl_clock(i_scl_clock), .i_sda_in(i_sda_in), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .i_addr_sel(i_addr_sel), .i_pin_level_bits(i_pin_level_bits), .o_port_ctl(o_port_ctl));

// ===== verif/test_gexp_regs.sv
`timescale 1ns/10ps
module test_gexp_regs
  import gexp_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b0;
  logic [7:0] pins = 8'h00;
  logic scl;
  logic sda;
  logic sda_oe;
  gexp_port_ctl_t ctl;
  logic [7:0] rm [0:255];
  logic [31:0] seed = 32'h0ded16bb;
  logic [7:0] rw_codes [10] = '{8'h01, 8'h02, 8'h03, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44,
    8'h45, 8'h4f};
  logic [7:0] rw_rst [10] = '{8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff,
    8'h00};
  logic [7:0] odd_codes [4] = '{8'h00, 8'h46, 8'h4e, 8'hce};
  int fails = 0;
  int check_count = 0;
  always #12.5 clk = ~clk;
  gexp_master m (.i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
  gexp_regs dut (.i_clock(clk), .i_resetn(rst_n), .i_scl_clock(scl), .i_sda_in(sda),
    .o_sda_out(), .o_sda_oe(sda_oe), .i_addr_sel(sel), .i_pin_level_bits(pins),
    .o_port_ctl(ctl));
  // ****************
  // Reference model and checks
  // ****************
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  task automatic model_reset();
    for (int i = 0; i < 256; i++) begin
      rm[i] = 8'h00;
    end
    foreach (rw_codes[i]) begin
      rm[rw_codes[i]] = rw_rst[i];
    end
  endtask
  task automatic model_write(input logic [7:0] p, input logic [7:0] d);
    foreach (rw_codes[i]) begin
      if (rw_codes[i] == p) begin
        rm[p] = (p == 8'h4f) ? (d & 8'h01) : d;
      end
    end
  endtask
  function automatic logic [7:0] exp_read(input logic [7:0] p);
    if (p == 8'h00) begin
      return pins ^ (rm[8'h02] & rm[8'h03]);
    end
    return rm[p];
  endfunction
  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_port();
    gexp_port_ctl_t e;
    e.pin_drive = rm[8'h01];
    e.pin_oe = ~rm[8'h03];
    e.drive_strength_fields = {rm[8'h41], rm[8'h40]};
    e.pull_enable = rm[8'h43];
    e.pull_select = rm[8'h44];
    e.open_drain = rm[8'h4f][0];
    check_count++;
    if (ctl !== e) begin
      fails++;
      $display("wrong value port control expected %h seen %h", e, ctl);
    end
  endtask
  task automatic frame(input logic [6:0] a, input logic [7:0] p, input logic rd,
      input logic [7:0] d);
    logic [7:0] q;
    logic k;
    logic hit;
    @(negedge clk);
    pins = rnd();
    hit = (a == {GEXP_ADDR_BASE, sel});
    m.start(1'b0);
    m.xfer({a, 1'b0}, 1'b1, q, k);
    chk_byte("address ack", {7'h00, ~hit}, {7'h00, k});
    if (hit) begin
      m.xfer(p, 1'b1, q, k);
      if (rd) begin
        m.start(1'b1);
        m.xfer({a, 1'b1}, 1'b1, q, k);
        m.xfer(8'hff, 1'b1, q, k);
        chk_byte("read data", exp_read(p), q);
      end else begin
        m.xfer(d, 1'b1, q, k);
        model_write(p, d);
      end
    end
    m.stop();
    repeat (4) @(negedge clk);
    chk_port();
  endtask
  task automatic read_all();
    foreach (rw_codes[i]) begin
      frame({GEXP_ADDR_BASE, sel}, rw_codes[i], 1'b1, 8'h00);
    end
    foreach (odd_codes[i]) begin
      frame({GEXP_ADDR_BASE, sel}, odd_codes[i], 1'b1, 8'h00);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    conclude();
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    model_reset();
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk_port();
    read_all();
    $display("test reset values done");
    for (int r = 0; r < 2; r++) begin
      @(negedge clk);
      sel = r[0];
      foreach (rw_codes[i]) begin
        frame({GEXP_ADDR_BASE, sel}, rw_codes[i], 1'b0, rnd());
      end
      foreach (odd_codes[i]) begin
        frame({GEXP_ADDR_BASE, sel}, odd_codes[i], 1'b0, rnd());
      end
      frame({GEXP_ADDR_BASE, ~sel}, 8'h03, 1'b0, 8'h00);
      read_all();
      $display("test write round %0d done", r);
    end
    @(negedge clk);
    rst_n = 1'b0;
    model_reset();
    repeat (16) @(negedge clk);
    chk_port();
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    read_all();
    $display("test second reset done");
    conclude();
  end
endmodule
